/* File: tpgwi_top.sv */
// Two-port GPIO block with Port A interrupts behind an APB slave.
// Assumes one clock ref_clk at 250 MHz and pads asynchronous to it.
`timescale 1ns/10ps

module tpgwi_top (
   input  wire logic                           ref_clk,
   input  wire logic                           arst_n,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire tpgwi_pkg::tpgwi_addr_t         paddr,
   input  wire tpgwi_pkg::tpgwi_data_t         pwdata,
   output tpgwi_pkg::tpgwi_data_t              prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic [tpgwi_pkg::PORT_A_W-1:0] portAIn,
   output logic      [tpgwi_pkg::PORT_A_W-1:0] portAOut,
   output logic      [tpgwi_pkg::PORT_A_W-1:0] portAOeN,
   input  wire logic [tpgwi_pkg::PORT_A_W-1:0] hwAOut,
   input  wire logic [tpgwi_pkg::PORT_A_W-1:0] hwADir,
   output logic      [tpgwi_pkg::PORT_A_W-1:0] portASync,
   input  wire logic [tpgwi_pkg::PORT_B_W-1:0] secondIoPortIn,
   output logic      [tpgwi_pkg::PORT_B_W-1:0] secondIoPortOut,
   output logic      [tpgwi_pkg::PORT_B_W-1:0] secondIoPortOeN,
   input  wire logic [tpgwi_pkg::PORT_B_W-1:0] hwBOut,
   input  wire logic [tpgwi_pkg::PORT_B_W-1:0] hwBDir,
   output logic      [tpgwi_pkg::PORT_B_W-1:0] secondIoPortSync,
   output logic                                irq
);
   import tpgwi_pkg::*;

   // Software-visible state
   // Only the live low bits are stored; reserved bits cost no flops
   // and read back as zero without any extra masking
   logic [PORT_A_W-1:0] aData_reg,   aData_next;
   logic [PORT_A_W-1:0] aDir_reg,    aDir_next;
   logic                aSrc_reg,    aSrc_next;
   logic [PORT_B_W-1:0] bData_reg,   bData_next;
   logic [PORT_B_W-1:0] bDir_reg,    bDir_next;
   logic                bSrc_reg,    bSrc_next;
   logic [PORT_A_W-1:0] irqEn_reg,   irqEn_next;
   logic [PORT_A_W-1:0] irqMask_reg, irqMask_next;
   logic [PORT_A_W-1:0] irqType_reg, irqType_next;
   logic [PORT_A_W-1:0] irqPol_reg,  irqPol_next;

   // Bus answer and interrupt line
   // Registered so every top output leaves a flop; the price is one
   // access cycle per transfer, never more
   tpgwi_data_t         rdata_reg,   rdata_next;
   logic                ready_reg,   ready_next;
   logic                err_reg,     err_next;
   logic                irq_reg,     irq_next;

   // Transfer qualifiers
   // Combinational, from this cycle's bus inputs, the registered reply and the interrupt status
   logic                setupPhase;
   logic                wrTake;
   logic                rdTake;
   logic [PORT_A_W-1:0] eoiClr;
   logic                statReadClr;
   logic [PORT_A_W-1:0] rawStat;
   logic [PORT_A_W-1:0] maskedStat;
   logic [PORT_A_W-1:0] aExt;
   logic [PORT_B_W-1:0] bExt;
   logic                mapped;

   // One carrier per port; the pin end owns the pad synchroniser
   tpgwi_port_if #(.W(PORT_A_W)) portAIf ();
   tpgwi_port_if #(.W(PORT_B_W)) portBIf ();

   // Address compare, shared by decode, read mux and write enables
   // Exact byte match; misaligned addresses simply miss every word
   function automatic logic hit(input tpgwi_addr_t a, input tpgwi_addr_t off);
      hit = (a == off);
   endfunction

   // Is the address one of the mapped words
   // Words left out (debounce, level sync, identity) miss here and
   // answer with an error rather than silent zeros
   function automatic logic isMapped(input tpgwi_addr_t a);
      isMapped = hit(a, OFF_A_DATA)   | hit(a, OFF_A_DIR)    | hit(a, OFF_A_SRC)
               | hit(a, OFF_B_DATA)   | hit(a, OFF_B_DIR)    | hit(a, OFF_B_SRC)
               | hit(a, OFF_IRQ_EN)   | hit(a, OFF_IRQ_MASK) | hit(a, OFF_IRQ_TYPE)
               | hit(a, OFF_IRQ_POL)  | hit(a, OFF_IRQ_STAT) | hit(a, OFF_IRQ_RAW)
               | hit(a, OFF_IRQ_EOI)  | hit(a, OFF_A_EXT)    | hit(a, OFF_B_EXT);
   endfunction

   // Register values toward the pin logic
   // Plain wiring; the pin end registers before the pads
   always_comb begin
      portAIf.swData = aData_reg;
      portAIf.swDir  = aDir_reg;
      portAIf.hwSel  = aSrc_reg;
      portBIf.swData = bData_reg;
      portBIf.swDir  = bDir_reg;
      portBIf.hwSel  = bSrc_reg;
   end

   // Port A pins; hardware mode takes hwAOut and hwADir
   tpgwi_port #(.W(PORT_A_W)) uPortA (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .cfg     (portAIf),
      .hwOut   (hwAOut),
      .hwDir   (hwADir),
      .padIn   (portAIn),
      .padOut  (portAOut),
      .padOeN  (portAOeN)
   );

   // Second port pins; hardware mode takes hwBOut and hwBDir
   tpgwi_port #(.W(PORT_B_W)) uPortB (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .cfg     (portBIf),
      .hwOut   (hwBOut),
      .hwDir   (hwBDir),
      .padIn   (secondIoPortIn),
      .padOut  (secondIoPortOut),
      .padOeN  (secondIoPortOeN)
   );

   // Port A interrupt detection on the synchronised levels;
   // raw pad levels never reach the edge detector
   tpgwi_irq #(.W(PORT_A_W)) uIrq (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .padIn      (portAIf.padSync),
      .irqEn      (irqEn_reg),
      .irqEdge    (irqType_reg),
      .irqPol     (irqPol_reg),
      .irqMask    (irqMask_reg),
      .eoiClr     (eoiClr),
      .rawStat    (rawStat),
      .maskedStat (maskedStat)
   );

   // Bus phase decode; a write lands on the edge that samples pready
   // An erroring transfer neither writes nor clears; a status read
   // clears only on its completing edge, and only the bits it returned,
   // so an edge latched after the read data was built is kept
   always_comb begin
      setupPhase  = psel & ~penable;
      wrTake      = psel & penable & ready_reg & pwrite & ~err_reg;
      rdTake      = psel & penable & ready_reg & ~pwrite & ~err_reg;
      statReadClr = rdTake & hit(paddr, OFF_IRQ_STAT);
      eoiClr      = ((wrTake & hit(paddr, OFF_IRQ_EOI)) ? pwdata[PORT_A_W-1:0] : A_RST)
                  | (statReadClr ? rdata_reg[PORT_A_W-1:0] : A_RST);  // Read clears what it reported
      mapped      = isMapped(paddr);
   end

   // External view: pad for inputs, stored data for outputs
   // Uses the software direction even in hardware mode; software
   // must keep both directions alike for a faithful view
   always_comb begin
      aExt = (aDir_reg & aData_reg) | (~aDir_reg & portAIf.padSync);
      bExt = (bDir_reg & bData_reg) | (~bDir_reg & portBIf.padSync);
   end

   // Next values of the writable registers; upper bits are dropped
   // Each word decodes on its own; read-only and unmapped words
   // fall through with every register holding its value
   always_comb begin
      aData_next   = aData_reg;
      aDir_next    = aDir_reg;
      aSrc_next    = aSrc_reg;
      bData_next   = bData_reg;
      bDir_next    = bDir_reg;
      bSrc_next    = bSrc_reg;
      irqEn_next   = irqEn_reg;
      irqMask_next = irqMask_reg;
      irqType_next = irqType_reg;
      irqPol_next  = irqPol_reg;
      if (wrTake) begin
         if (hit(paddr, OFF_A_DATA)) begin
            aData_next = pwdata[PORT_A_W-1:0];
         end
         if (hit(paddr, OFF_A_DIR)) begin
            aDir_next = pwdata[PORT_A_W-1:0];
         end
         if (hit(paddr, OFF_A_SRC)) begin
            aSrc_next = pwdata[SRC_BIT];
         end
         if (hit(paddr, OFF_B_DATA)) begin
            bData_next = pwdata[PORT_B_W-1:0];
         end
         if (hit(paddr, OFF_B_DIR)) begin
            bDir_next = pwdata[PORT_B_W-1:0];
         end
         if (hit(paddr, OFF_B_SRC)) begin
            bSrc_next = pwdata[SRC_BIT];
         end
         if (hit(paddr, OFF_IRQ_EN)) begin
            irqEn_next = pwdata[PORT_A_W-1:0];
         end
         if (hit(paddr, OFF_IRQ_MASK)) begin
            irqMask_next = pwdata[PORT_A_W-1:0];
         end
         if (hit(paddr, OFF_IRQ_TYPE)) begin
            irqType_next = pwdata[PORT_A_W-1:0];
         end
         if (hit(paddr, OFF_IRQ_POL)) begin
            irqPol_next = pwdata[PORT_A_W-1:0];
         end
      end
   end

   // Read data is built in the setup cycle so it stands during access
   // Status is a snapshot of the setup cycle; an edge that arrives
   // later is left latched for the next read rather than lost
   always_comb begin
      rdata_next = DATA_ZERO;
      ready_next = setupPhase;
      err_next   = setupPhase & ~mapped;           // Unmapped words answer with an error
      if (setupPhase & ~pwrite) begin
         unique case (1'b1)
            hit(paddr, OFF_A_DATA):   rdata_next[PORT_A_W-1:0] = aData_reg;
            hit(paddr, OFF_A_DIR):    rdata_next[PORT_A_W-1:0] = aDir_reg;
            hit(paddr, OFF_A_SRC):    rdata_next[SRC_BIT]      = aSrc_reg;
            hit(paddr, OFF_B_DATA):   rdata_next[PORT_B_W-1:0] = bData_reg;
            hit(paddr, OFF_B_DIR):    rdata_next[PORT_B_W-1:0] = bDir_reg;
            hit(paddr, OFF_B_SRC):    rdata_next[SRC_BIT]      = bSrc_reg;
            hit(paddr, OFF_IRQ_EN):   rdata_next[PORT_A_W-1:0] = irqEn_reg;
            hit(paddr, OFF_IRQ_MASK): rdata_next[PORT_A_W-1:0] = irqMask_reg;
            hit(paddr, OFF_IRQ_TYPE): rdata_next[PORT_A_W-1:0] = irqType_reg;
            hit(paddr, OFF_IRQ_POL):  rdata_next[PORT_A_W-1:0] = irqPol_reg;
            hit(paddr, OFF_IRQ_STAT): rdata_next[PORT_A_W-1:0] = maskedStat;
            hit(paddr, OFF_IRQ_RAW):  rdata_next[PORT_A_W-1:0] = rawStat;
            hit(paddr, OFF_A_EXT):    rdata_next[PORT_A_W-1:0] = aExt;
            hit(paddr, OFF_B_EXT):    rdata_next[PORT_B_W-1:0] = bExt;
            default:                  rdata_next = DATA_ZERO;  // End-of-interrupt is write-only
         endcase
      end
   end

   // Level request; a blocked bit never reaches the line
   // One flop of delay keeps irq free of glitches while the
   // status terms settle within the cycle
   always_comb begin
      irq_next = |maskedStat;
   end

   // Registers; everything resets to software mode, inputs, no interrupts
   // Asynchronous assert so the block is quiet before any clock runs;
   // release is expected to be synchronised outside this block
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         aData_reg   <= A_RST;
         aDir_reg    <= A_RST;
         aSrc_reg    <= SRC_RST;
         bData_reg   <= B_RST;
         bDir_reg    <= B_RST;
         bSrc_reg    <= SRC_RST;
         irqEn_reg   <= A_RST;
         irqMask_reg <= A_RST;
         irqType_reg <= A_RST;
         irqPol_reg  <= A_RST;
         rdata_reg   <= DATA_ZERO;
         ready_reg   <= 1'b0;
         err_reg     <= 1'b0;
         irq_reg     <= 1'b0;
      end else begin
         aData_reg   <= aData_next;
         aDir_reg    <= aDir_next;
         aSrc_reg    <= aSrc_next;
         bData_reg   <= bData_next;
         bDir_reg    <= bDir_next;
         bSrc_reg    <= bSrc_next;
         irqEn_reg   <= irqEn_next;
         irqMask_reg <= irqMask_next;
         irqType_reg <= irqType_next;
         irqPol_reg  <= irqPol_next;
         rdata_reg   <= rdata_next;
         ready_reg   <= ready_next;
         err_reg     <= err_next;
         irq_reg     <= irq_next;
      end
   end

   // Outputs straight from flip-flops
   // Sync outputs let hardware users share the pad synchronisers
   assign prdata           = rdata_reg;
   assign pready           = ready_reg;
   assign pslverr          = err_reg;
   assign irq              = irq_reg;
   assign portASync        = portAIf.padSync;
   assign secondIoPortSync = portBIf.padSync;
endmodule

/* File: tpgwi_pkg.sv */
// Constants shared by the two-port GPIO block: widths, offsets, reset values.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
package tpgwi_pkg;
   localparam int unsigned PORT_A_W = 18;
   localparam int unsigned PORT_B_W = 17;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;

   typedef logic [ADDR_W-1:0] tpgwi_addr_t;
   typedef logic [DATA_W-1:0] tpgwi_data_t;

   // Register byte offsets
   localparam tpgwi_addr_t OFF_A_DATA    = 8'h00;
   localparam tpgwi_addr_t OFF_A_DIR     = 8'h04;
   localparam tpgwi_addr_t OFF_A_SRC     = 8'h08;
   localparam tpgwi_addr_t OFF_B_DATA    = 8'h0c;
   localparam tpgwi_addr_t OFF_B_DIR     = 8'h10;
   localparam tpgwi_addr_t OFF_B_SRC     = 8'h14;
   localparam tpgwi_addr_t OFF_IRQ_EN    = 8'h30;
   localparam tpgwi_addr_t OFF_IRQ_MASK  = 8'h34;
   localparam tpgwi_addr_t OFF_IRQ_TYPE  = 8'h38;
   localparam tpgwi_addr_t OFF_IRQ_POL   = 8'h3c;
   localparam tpgwi_addr_t OFF_IRQ_STAT  = 8'h40;
   localparam tpgwi_addr_t OFF_IRQ_RAW   = 8'h44;
   localparam tpgwi_addr_t OFF_IRQ_EOI   = 8'h4c;
   localparam tpgwi_addr_t OFF_A_EXT     = 8'h50;
   localparam tpgwi_addr_t OFF_B_EXT     = 8'h54;

   // Field positions and reset values
   localparam int unsigned SRC_BIT       = 0;
   localparam logic        SRC_RST       = 1'b0;
   localparam logic [PORT_A_W-1:0] A_RST = 18'h00000;
   localparam logic [PORT_B_W-1:0] B_RST = 17'h00000;
   localparam tpgwi_data_t DATA_ZERO     = 32'h00000000;
endpackage

/* File: tpgwi_port_if.sv */
// Carrier between the register block and one port's pin logic.
// Assumes both ends run on the same clock; the port end synchronises pads.
`timescale 1ns/10ps
interface tpgwi_port_if #(
   parameter int unsigned W = 18
);
   logic [W-1:0] swData;
   logic [W-1:0] swDir;
   logic         hwSel;
   logic [W-1:0] padSync;

   modport ctrl (output swData, output swDir, output hwSel, input padSync);
   modport pins (input swData, input swDir, input hwSel, output padSync);
endinterface

/* File: tpgwi_port.sv */
// Pin logic of one GPIO port: source mux, registered drive, pad synchroniser.
// Assumes pads are asynchronous to ref_clk; output enable is active low.
`timescale 1ns/10ps
module tpgwi_port #(
   parameter int unsigned W = 18
) (
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   tpgwi_port_if.pins        cfg,
   input  wire logic [W-1:0] hwOut,
   input  wire logic [W-1:0] hwDir,
   input  wire logic [W-1:0] padIn,
   output logic      [W-1:0] padOut,
   output logic      [W-1:0] padOeN
);
   import tpgwi_pkg::*;

   logic [W-1:0] meta_reg,  meta_next;
   logic [W-1:0] sync_reg,  sync_next;
   logic [W-1:0] out_reg,   out_next;
   logic [W-1:0] oeN_reg,   oeN_next;

   // Source mux; direction bit 1 drives the pad
   always_comb begin
      meta_next = padIn;
      sync_next = meta_reg;
      out_next  = cfg.hwSel ? hwOut : cfg.swData;
      oeN_next  = ~(cfg.hwSel ? hwDir : cfg.swDir);
   end

   // All bits reset to input, pads undriven
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         out_reg  <= '0;
         oeN_reg  <= '1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         out_reg  <= out_next;
         oeN_reg  <= oeN_next;
      end
   end

   assign cfg.padSync = sync_reg;  // Only the second stage leaves the module
   assign padOut      = out_reg;
   assign padOeN      = oeN_reg;
endmodule

/* File: tpgwi_irq.sv */
// Port A interrupt detection: level or edge, either polarity, edge latches.
// Assumes padIn is already synchronised to ref_clk.
`timescale 1ns/10ps
module tpgwi_irq #(
   parameter int unsigned W = 18
) (
   input  wire logic         ref_clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] padIn,
   input  wire logic [W-1:0] irqEn,
   input  wire logic [W-1:0] irqEdge,
   input  wire logic [W-1:0] irqPol,
   input  wire logic [W-1:0] irqMask,
   input  wire logic [W-1:0] eoiClr,
   output logic      [W-1:0] rawStat,
   output logic      [W-1:0] maskedStat
);
   import tpgwi_pkg::*;

   logic [W-1:0] prev_reg,  prev_next;
   logic [W-1:0] latch_reg, latch_next;
   logic [W-1:0] active;
   logic [W-1:0] edgeHit;

   // Detection; a new edge wins over a clear in the same cycle
   always_comb begin
      active     = (irqPol & padIn) | (~irqPol & ~padIn);
      edgeHit    = (irqPol & padIn & ~prev_reg) | (~irqPol & ~padIn & prev_reg);
      prev_next  = padIn;
      latch_next = (latch_reg & ~eoiClr)
                 | (irqEn & irqEdge & edgeHit);
      rawStat    = (irqEn & ~irqEdge & active) | (irqEn & irqEdge & latch_reg);
      maskedStat = rawStat & ~irqMask;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_reg  <= '0;
         latch_reg <= '0;
      end else begin
         prev_reg  <= prev_next;
         latch_reg <= latch_next;
      end
   end
endmodule

/* File: tpgwi_top_chk.sv */
// Checker for the two-port GPIO top: APB timing, pad drive, reserved bits.
// Assumes it is bound to tpgwi_top and sees only that module's ports.
`timescale 1ns/10ps
module tpgwi_top_chk (
   input wire logic                           ref_clk,
   input wire logic                           arst_n,
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire tpgwi_pkg::tpgwi_addr_t         paddr,
   input wire tpgwi_pkg::tpgwi_data_t         pwdata,
   input wire tpgwi_pkg::tpgwi_data_t         prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   input wire logic [tpgwi_pkg::PORT_A_W-1:0] portAOut,
   input wire logic [tpgwi_pkg::PORT_A_W-1:0] portAOeN,
   input wire logic [tpgwi_pkg::PORT_A_W-1:0] hwAOut,
   input wire logic [tpgwi_pkg::PORT_A_W-1:0] hwADir,
   input wire logic [tpgwi_pkg::PORT_B_W-1:0] secondIoPortOut,
   input wire logic [tpgwi_pkg::PORT_B_W-1:0] secondIoPortOeN
);
   import tpgwi_pkg::*;
   logic srcA;
   logic srcB;
   logic wrEdge;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Completed write at this edge
   assign wrEdge = psel && penable && pready && pwrite;
   // Mirror of the source bits, so pad checks know who owns the pins
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         srcA <= 1'b0;
         srcB <= 1'b0;
      end else if (wrEdge && paddr == OFF_A_SRC) begin
         srcA <= pwdata[0];
      end else if (wrEdge && paddr == OFF_B_SRC) begin
         srcB <= pwdata[0];
      end
   end
   a_ready_one: assert property (pready |=> !pready) else $error("ready held too long");
   a_setup_answer: assert property (psel && !penable |=> pready) else $error("no answer in access");
   a_err_clean: assert property (pslverr |-> pready && prdata == DATA_ZERO) else $error("bad error reply");
   a_reserved_zero: assert property (pready && !pwrite |-> prdata[31:18] == 14'h0000)
      else $error("upper read bits set");
   a_dir_to_oe: assert property (wrEdge && paddr == OFF_A_DIR && !srcA |->
      ##2 portAOeN == ~$past(pwdata[17:0], 2)) else $error("direction not on enables");
   a_a_drive: assert property (wrEdge && paddr == OFF_A_DATA && !srcA |->
      ##2 (portAOut & ~portAOeN) == ($past(pwdata[17:0], 2) & ~portAOeN)) else $error("A data not driven");
   a_b_drive: assert property (wrEdge && paddr == OFF_B_DATA && !srcB |-> ##2
      (secondIoPortOut & ~secondIoPortOeN) == ($past(pwdata[16:0], 2) & ~secondIoPortOeN))
      else $error("B data not driven");
   a_hw_drive: assert property (srcA && $past(srcA) |-> portAOut == $past(hwAOut) &&
      portAOeN == ~$past(hwADir)) else $error("hardware source not on pads");
endmodule
bind tpgwi_top tpgwi_top_chk i_tpgwi_top_chk (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .portAOut(portAOut), .portAOeN(portAOeN), .hwAOut(hwAOut), .hwADir(hwADir),
   .secondIoPortOut(secondIoPortOut), .secondIoPortOeN(secondIoPortOeN));

/* File: tpgwi_pad_model.sv */
// Pad model for one port: the outside world seen through the pins.
// Assumes active-low enables; undriven lines follow the bench level.
`timescale 1ns/10ps
module tpgwi_pad_model #(
   parameter int unsigned W = 18
) (
   input  wire logic [W-1:0] padOut,
   input  wire logic [W-1:0] padOeN,
   input  wire logic [W-1:0] extLevel,
   output logic      [W-1:0] padIn
);
   // Wire level: block drive wins where its enable is low
   assign padIn = (padOut & ~padOeN) | (extLevel & padOeN);
endmodule

/* File: tpgwi_top_tb.sv */
// Self-checking bench for the two-port GPIO: APB tasks and directed sequences.
// Assumes the pad models close the pins and a 4 ns clock.
`timescale 1ns/10ps
module tpgwi_top_tb;
   import tpgwi_pkg::*;
   logic                ref_clk = 1'b0;
   logic                arst_n  = 1'b0;
   logic                psel    = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite  = 1'b0;
   tpgwi_addr_t         paddr   = 8'h00;
   tpgwi_data_t         pwdata  = 32'h00000000;
   tpgwi_data_t         prdata;
   tpgwi_data_t         rdv;
   logic                pready, pslverr, irq, errv;
   logic [PORT_A_W-1:0] aIn, aOut, aOeN, aSync, hwAOut = 18'h00000, hwADir = 18'h00000, extA = 18'h00000;
   logic [PORT_B_W-1:0] bIn, bOut, bOeN, bSync, hwBOut = 17'h00000, hwBDir = 17'h00000, extB = 17'h00000;
   int                  n_fail = 0, n_checks = 0, cyc = 0;
   tpgwi_addr_t         addrs[10] = '{OFF_A_DATA, OFF_A_DIR, OFF_A_SRC, OFF_B_DATA, OFF_B_DIR,
                                      OFF_B_SRC, OFF_IRQ_EN, OFF_IRQ_MASK, OFF_IRQ_TYPE, OFF_IRQ_POL};
   tpgwi_data_t         masks[10] = '{32'h0003ffff, 32'h0003ffff, 32'h00000001, 32'h0001ffff,
                                      32'h0001ffff, 32'h00000001, 32'h0003ffff, 32'h0003ffff,
                                      32'h0003ffff, 32'h0003ffff};
   always #2 ref_clk = ~ref_clk;
   tpgwi_top i_tpgwi_top (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .portAIn(aIn), .portAOut(aOut), .portAOeN(aOeN), .hwAOut(hwAOut),
      .hwADir(hwADir), .portASync(aSync), .secondIoPortIn(bIn), .secondIoPortOut(bOut),
      .secondIoPortOeN(bOeN), .hwBOut(hwBOut), .hwBDir(hwBDir), .secondIoPortSync(bSync), .irq(irq));
   tpgwi_pad_model #(.W(PORT_A_W)) i_pad_a (.padOut(aOut), .padOeN(aOeN), .extLevel(extA), .padIn(aIn));
   tpgwi_pad_model #(.W(PORT_B_W)) i_pad_b (.padOut(bOut), .padOeN(bOeN), .extLevel(extB), .padIn(bIn));
   // Verdict and exit, shared by the sequence end and the hang guard
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input tpgwi_data_t got, input tpgwi_data_t exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer; the request is left up so a next setup can follow at once
   task automatic xfer(input logic w, input tpgwi_addr_t a, input tpgwi_data_t d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdv  = prdata;
      errv = pslverr;
   endtask
   task automatic wr(input tpgwi_addr_t a, input tpgwi_data_t d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input tpgwi_addr_t a, input tpgwi_data_t exp);
      xfer(1'b0, a, DATA_ZERO);
      chk(rdv, exp);
   endtask
   // Idle wait; releases the bus first
   task automatic waitc(input int n);
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask
   // Hang guard, far above the 189 cycles the sequence needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      waitc(4);
      arst_n <= 1'b1;
      chk(32'(aOeN), 32'h0003ffff);
      foreach (addrs[i]) rd(addrs[i], DATA_ZERO);
      foreach (addrs[i]) begin
         wr(addrs[i], 32'hffffffff);
         rd(addrs[i], masks[i]);
         wr(addrs[i], DATA_ZERO);
      end
      wr(OFF_IRQ_RAW, 32'hffffffff);
      rd(OFF_IRQ_RAW, DATA_ZERO);
      rd(OFF_IRQ_EOI, DATA_ZERO);
      xfer(1'b0, 8'h48, DATA_ZERO);
      chk(32'(errv), 32'h00000001);
      extA <= 18'h3c3c3;
      extB <= 17'h0f0f0;
      wr(OFF_A_DIR, 32'h00000f0f);
      wr(OFF_A_DATA, 32'h0002a5a5);
      wr(OFF_B_DIR, 32'h000100ff);
      wr(OFF_B_DATA, 32'h00015a5a);
      waitc(4);
      chk(32'(aOeN), 32'h0003f0f0);
      chk(32'(aOut & ~aOeN), 32'h00000505);
      chk(32'(bOeN), 32'h0000ff00);
      chk(32'(bOut & ~bOeN), 32'h0001005a);
      rd(OFF_A_EXT, 32'h0003c5c5);
      rd(OFF_B_EXT, 32'h0001f05a);
      chk(32'(aSync), 32'h0003c5c5);
      chk(32'(bSync), 32'h0001f05a);
      hwAOut <= 18'h12345;
      hwADir <= 18'h3ff00;
      hwBOut <= 17'h1abcd;
      hwBDir <= 17'h000ff;
      wr(OFF_A_SRC, 32'h00000001);
      wr(OFF_B_SRC, 32'h00000001);
      waitc(3);
      chk(32'(aOeN), 32'h000000ff);
      chk(32'(aOut & ~aOeN), 32'h00012300);
      chk(32'(bOeN), 32'h0001ff00);
      chk(32'(bOut & ~bOeN), 32'h000000cd);
      wr(OFF_A_SRC, DATA_ZERO);
      wr(OFF_B_SRC, DATA_ZERO);
      wr(OFF_A_DIR, DATA_ZERO);
      extA <= 18'h00000;
      wr(OFF_IRQ_POL, 32'h00000001);
      wr(OFF_IRQ_TYPE, 32'h00000002);
      wr(OFF_IRQ_EN, 32'h00000001);
      waitc(6);
      chk(32'(irq), 32'h00000000);
      extA <= 18'h00001;
      waitc(6);
      chk(32'(irq), 32'h00000001);
      rd(OFF_IRQ_STAT, 32'h00000001);
      wr(OFF_IRQ_MASK, 32'h00000001);
      waitc(3);
      chk(32'(irq), 32'h00000000);
      rd(OFF_IRQ_STAT, DATA_ZERO);
      rd(OFF_IRQ_RAW, 32'h00000001);
      wr(OFF_IRQ_MASK, DATA_ZERO);
      wr(OFF_IRQ_EN, 32'h00000006);
      waitc(6);
      rd(OFF_IRQ_RAW, 32'h00000004);
      extA <= 18'h00006;
      waitc(6);
      chk(32'(irq), 32'h00000000);
      extA <= 18'h00004;
      waitc(6);
      chk(32'(irq), 32'h00000001);
      rd(OFF_IRQ_RAW, 32'h00000002);
      wr(OFF_IRQ_EOI, DATA_ZERO);
      rd(OFF_IRQ_RAW, 32'h00000002);
      wr(OFF_IRQ_EOI, 32'h00000002);
      waitc(3);
      chk(32'(irq), 32'h00000000);
      rd(OFF_IRQ_RAW, DATA_ZERO);
      waitc(2);
      end_of_test();
   end
endmodule
